// ===== rtl/mtd_cfg.svh
/*
 * Constants of the meter management token decoder: token field positions,
 * class and subclass codes, limits, register offsets and control bits.
 * Assumes it is included by bare name before the package and before modules.
 */
`ifndef MTD_CFG_SVH
`define MTD_CFG_SVH

`define MTD_TOK_W        66
// Field positions, counted from bit 0 upward
`define MTD_CLASS_HI     65
`define MTD_CLASS_LO     64
`define MTD_SUB_HI       63
`define MTD_SUB_LO       60
`define MTD_CRC_HI       15
`define MTD_CRC_LO       0
`define MTD_VAL16_HI     31
`define MTD_VAL16_LO     16
`define MTD_KEXP_HI      59
`define MTD_KEXP_LO      56
`define MTD_KREV_HI      55
`define MTD_KREV_LO      52
`define MTD_ROLL_BIT     51
`define MTD_TRIP_BIT     50
`define MTD_KKIND_HI     49
`define MTD_KKIND_LO     48
`define MTD_KEY_HI       47
`define MTD_KEY_LO       16
`define MTD_TIDX_HI      55
`define MTD_TIDX_LO      48
`define MTD_SG24_HI      59
`define MTD_SG24_LO      36
`define MTD_RESA_HI      35
`define MTD_RESA_LO      16
`define MTD_SG12_HI      59
`define MTD_SG12_LO      48
`define MTD_CTL36_HI     59
`define MTD_CTL36_LO     24
`define MTD_MC8_HI       23
`define MTD_MC8_LO       16
`define MTD_CTL28_HI     59
`define MTD_CTL28_LO     32
`define MTD_MC16_HI      31
`define MTD_MC16_LO      16

// Class codes
`define MTD_CLS_CREDIT   2'h0
`define MTD_CLS_TEST     2'h1
`define MTD_CLS_MGMT     2'h2
`define MTD_CLS_RSVD     2'h3

// Class 1 subclasses
`define MTD_T1_TWO_DIG   4'h0
`define MTD_T1_FOUR_DIG  4'h1

// Class 2 subclasses
`define MTD_S_POWER      4'h0
`define MTD_S_CLEAR      4'h1
`define MTD_S_TARIFF     4'h2
`define MTD_S_KEY1       4'h3
`define MTD_S_KEY2       4'h4
`define MTD_S_TAMPER     4'h5
`define MTD_S_UNBAL      4'h6
`define MTD_S_WATER      4'h7
`define MTD_S_KEY3       4'h8
`define MTD_S_KEY4       4'h9
`define MTD_S_MAKER_LO   4'hb

// Limits
`define MTD_KREV_MIN     4'h1
`define MTD_KREV_MAX     4'h9
`define MTD_TIDX_MAX     8'h63
`define MTD_SG_MAX       24'hf423f

// Register indices on the plain port
`define MTD_A_CTRL       4'h0
`define MTD_A_STATUS     4'h1
`define MTD_A_POWER      4'h2
`define MTD_A_UNBAL      4'h3
`define MTD_A_WATER      4'h4
`define MTD_A_CLRSEL     4'h5
`define MTD_A_KEY0       4'h6
`define MTD_A_KEY1       4'h7
`define MTD_A_KEY2       4'h8
`define MTD_A_KEY3       4'h9
`define MTD_A_KEYINFO    4'ha
`define MTD_A_SUPPLY     4'hb
`define MTD_A_TESTCTL    4'hc
`define MTD_A_MAKER      4'hd

// Control register bits
`define MTD_C_FOUR_DIG   0
`define MTD_C_ALT_FMT    1
`define MTD_C_TRIPLET    2
`define MTD_C_WIDE_KEY   3
`define MTD_C_TAMPER     4

`endif

// ===== rtl/mtd_pkg.sv
/*
 * Types of the meter management token decoder.
 * Assumes mtd_cfg.svh supplies the widths that the types use.
 */
`include "mtd_cfg.svh"
package mtd_pkg;

    typedef logic [`MTD_TOK_W-1:0] mtd_tok_t;

    typedef enum logic [3:0] {
        MTD_IDLE  = 4'b0001,
        MTD_CHECK = 4'b0010,
        MTD_APPLY = 4'b0100,
        MTD_DONE  = 4'b1000
    } mtd_state_e;

    // Register port from software
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mtd_bus_s;

    // Token verdict
    typedef struct packed {
        logic accepted;
        logic rejected;
    } mtd_verdict_s;

    // Key change progress
    typedef struct packed {
        logic [3:0]   got;
        logic [127:0] key;
        logic [23:0]  supply;
        logic [7:0]   expiry;
        logic [3:0]   revision;
        logic         rollover;
        logic [1:0]   kind;
        logic [7:0]   tariff;
        logic         triplet;
    } mtd_key_s;

    // All state of the top
    typedef struct packed {
        mtd_state_e   st;
        mtd_tok_t     tok;
        logic [4:0]   ctrl;
        logic [15:0]  power;
        logic [15:0]  unbal;
        logic [15:0]  water;
        logic [15:0]  clrsel;
        logic         clr_pulse;
        logic         tamper_clr;
        logic [35:0]  testctl;
        logic         test_go;
        logic [15:0]  maker;
        logic         maker_go;
        mtd_key_s     kst;
        logic [127:0] key_live;
        logic [23:0]  sg_live;
        logic         key_done;
        mtd_verdict_s vd;
        logic [31:0]  rdata;
        logic         busy;
    } mtd_state_s;

endpackage : mtd_pkg

// ===== rtl/mtd_crc16.sv
/*
 * Checksum unit: folds a 50-bit token body into a 16-bit check value.
 * Assumes the check word is the low 16 bits of the token; the polynomial
 * is a parameter since the exact algorithm is held outside this block.
 */
`timescale 1ns/1ps
`default_nettype none
module mtd_crc16
    import mtd_pkg::*;
#(
    parameter logic [15:0] POLY = 16'h8005
) (
    // Token in
    input  wire logic [49:0] body,
    input  wire logic [15:0] check,
    // Verdict
    output var  logic        ok
);
    logic [15:0] crc;

    always_comb begin
        crc = 16'hffff;
        for (int i = 49; i >= 0; i--) begin
            if (crc[15] ^ body[i]) begin
                crc = {crc[14:0], 1'b0} ^ POLY;
            end else begin
                crc = {crc[14:0], 1'b0};
            end
        end
        ok = (crc == check);
    end
endmodule // mtd_crc16
`default_nettype wire

// ===== rtl/mtd_token_decoder.sv
/*
 * Meter management token decoder: takes one 66-bit token at a time, checks
 * it and performs the class 1 and class 2 management and key change actions.
 * Assumes a token carrier strobing tokens from the same clock domain, and
 * software on a plain register port with read data one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mtd_cfg.svh"
module mtd_token_decoder
    import mtd_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Token carrier
    input  wire mtd_tok_t     tok_in,
    input  wire logic         tok_valid,
    output var  logic         tok_busy,
    // Register port
    input  wire mtd_bus_s     bus,
    output var  logic [31:0]  rdata,
    // Meter side
    input  wire logic         tamper_in,
    output var  logic [15:0]  credit_clear_sel,
    output var  logic         credit_clear,
    output var  logic         tamper_clear,
    output var  logic [35:0]  test_control,
    output var  logic         test_start,
    output var  logic [15:0]  maker_payload,
    output var  logic         maker_start,
    output var  mtd_verdict_s verdict
);
    mtd_state_s q;
    mtd_state_s d;
    logic       crc_ok;
    logic [1:0] cls;
    logic [3:0] sub;
    logic       legal;

    mtd_crc16 u_crc (
        .body  (q.tok[`MTD_CLASS_HI:`MTD_VAL16_LO]),
        .check (q.tok[`MTD_CRC_HI:`MTD_CRC_LO]),
        .ok    (crc_ok)
    );

    assign cls = q.tok[`MTD_CLASS_HI:`MTD_CLASS_LO];
    assign sub = q.tok[`MTD_SUB_HI:`MTD_SUB_LO];

    function automatic logic [15:0] val16(input mtd_tok_t t);
        return t[`MTD_VAL16_HI:`MTD_VAL16_LO];
    endfunction

    // Which class and subclass pairs this meter acts on
    always_comb begin
        legal = 1'b0;
        if (cls == `MTD_CLS_TEST) begin
            if (sub == `MTD_T1_TWO_DIG) begin
                legal = !q.ctrl[`MTD_C_FOUR_DIG] || q.ctrl[`MTD_C_ALT_FMT];
            end else if (sub == `MTD_T1_FOUR_DIG) begin
                legal = q.ctrl[`MTD_C_FOUR_DIG] || q.ctrl[`MTD_C_ALT_FMT];
            end
        end else if (cls == `MTD_CLS_MGMT) begin
            case (sub)
                `MTD_S_POWER, `MTD_S_CLEAR, `MTD_S_TAMPER,
                `MTD_S_UNBAL, `MTD_S_WATER: legal = 1'b1;
                `MTD_S_KEY1: legal = q.tok[`MTD_KREV_HI:`MTD_KREV_LO]
                                     >= `MTD_KREV_MIN
                                  && q.tok[`MTD_KREV_HI:`MTD_KREV_LO]
                                     <= `MTD_KREV_MAX;
                `MTD_S_KEY2: legal = q.tok[`MTD_TIDX_HI:`MTD_TIDX_LO]
                                     <= `MTD_TIDX_MAX;
                `MTD_S_KEY3: legal = q.ctrl[`MTD_C_WIDE_KEY]
                    || (q.ctrl[`MTD_C_TRIPLET]
                        && q.tok[`MTD_SG24_HI:`MTD_SG24_LO] <= `MTD_SG_MAX
                        && q.tok[`MTD_RESA_HI:`MTD_RESA_LO] == 20'h0);
                `MTD_S_KEY4: legal = q.ctrl[`MTD_C_WIDE_KEY];
                default: legal = (sub >= `MTD_S_MAKER_LO);
            endcase
        end
        // Class 0 is handled elsewhere; class 3 reserved
    end

    always_comb begin
        d = q;
        d.clr_pulse  = 1'b0;
        d.tamper_clr = 1'b0;
        d.test_go    = 1'b0;
        d.maker_go   = 1'b0;
        d.key_done   = 1'b0;
        d.vd         = '0;
        d.rdata      = 32'h0;

        // Tamper condition holds the sticky bit until a clear token
        if (tamper_in) begin
            d.ctrl[`MTD_C_TAMPER] = 1'b1;
        end

        case (q.st)
            MTD_IDLE: begin
                if (tok_valid) begin
                    d.tok  = tok_in;
                    d.busy = 1'b1;
                    d.st   = MTD_CHECK;
                end
            end
            MTD_CHECK: begin
                if (crc_ok && legal) begin
                    d.st = MTD_APPLY;
                end else begin
                    d.vd.rejected = 1'b1;
                    d.st = MTD_DONE;
                end
            end
            MTD_APPLY: begin
                d.vd.accepted = 1'b1;
                d.st = MTD_DONE;
                if (cls == `MTD_CLS_TEST) begin
                    d.test_go = 1'b1;
                    if (sub == `MTD_T1_TWO_DIG) begin
                        d.testctl = q.tok[`MTD_CTL36_HI:`MTD_CTL36_LO];
                    end else begin
                        d.testctl = {8'h0,
                            q.tok[`MTD_CTL28_HI:`MTD_CTL28_LO]};
                    end
                end else begin
                    case (sub)
                        `MTD_S_POWER: d.power = val16(q.tok);
                        `MTD_S_CLEAR: begin
                            d.clrsel    = val16(q.tok);
                            d.clr_pulse = 1'b1;
                        end
                        `MTD_S_TAMPER: begin
                            d.ctrl[`MTD_C_TAMPER] = tamper_in;
                            d.tamper_clr = 1'b1;
                        end
                        `MTD_S_UNBAL: d.unbal = val16(q.tok);
                        `MTD_S_WATER: d.water = val16(q.tok);
                        `MTD_S_KEY1: begin
                            d.kst.got      = 4'h1;
                            d.kst.expiry[7:4] =
                                q.tok[`MTD_KEXP_HI:`MTD_KEXP_LO];
                            d.kst.revision = q.tok[`MTD_KREV_HI:`MTD_KREV_LO];
                            d.kst.rollover = q.tok[`MTD_ROLL_BIT];
                            d.kst.triplet  = q.tok[`MTD_TRIP_BIT];
                            d.kst.kind     = q.tok[`MTD_KKIND_HI:`MTD_KKIND_LO];
                            d.kst.key[127:96] =
                                q.tok[`MTD_KEY_HI:`MTD_KEY_LO];
                        end
                        `MTD_S_KEY2: begin
                            d.kst.got[1]  = 1'b1;
                            d.kst.tariff  = q.tok[`MTD_TIDX_HI:`MTD_TIDX_LO];
                            d.kst.expiry[3:0] =
                                q.tok[`MTD_KEXP_HI:`MTD_KEXP_LO];
                            d.kst.key[31:0] =
                                q.tok[`MTD_KEY_HI:`MTD_KEY_LO];
                        end
                        `MTD_S_KEY3: begin
                            d.kst.got[2] = 1'b1;
                            if (q.ctrl[`MTD_C_WIDE_KEY]) begin
                                d.kst.supply[11:0] =
                                    q.tok[`MTD_SG12_HI:`MTD_SG12_LO];
                                d.kst.key[95:64] =
                                    q.tok[`MTD_KEY_HI:`MTD_KEY_LO];
                            end else begin
                                d.kst.supply =
                                    q.tok[`MTD_SG24_HI:`MTD_SG24_LO];
                            end
                        end
                        `MTD_S_KEY4: begin
                            d.kst.got[3] = 1'b1;
                            d.kst.supply[23:12] =
                                q.tok[`MTD_SG12_HI:`MTD_SG12_LO];
                            d.kst.key[63:32] =
                                q.tok[`MTD_KEY_HI:`MTD_KEY_LO];
                        end
                        default: begin
                            d.maker    = val16(q.tok);
                            d.maker_go = 1'b1;
                        end
                    endcase
                end
            end
            MTD_DONE: begin
                // Commit a completed key set
                if (q.ctrl[`MTD_C_WIDE_KEY] && q.kst.got == 4'hf) begin
                    d.key_live = q.kst.key;
                    d.sg_live  = q.kst.supply;
                    d.key_done = 1'b1;
                    d.kst.got  = 4'h0;
                end else if (!q.ctrl[`MTD_C_WIDE_KEY]
                             && q.kst.got[1:0] == 2'h3
                             && (!q.kst.triplet || q.kst.got[2])) begin
                    d.key_live = {64'h0, q.kst.key[127:96],
                                  q.kst.key[31:0]};
                    if (q.kst.triplet) begin
                        d.sg_live = q.kst.supply;
                    end
                    d.key_done = 1'b1;
                    d.kst.got  = 4'h0;
                end
                d.busy = 1'b0;
                d.st   = MTD_IDLE;
            end
            default: d.st = MTD_IDLE;
        endcase

        // Register writes; applied after the token logic above, so a write wins
        if (bus.wr) begin
            if (bus.addr == `MTD_A_CTRL) begin
                d.ctrl[3:0] = bus.wdata[3:0];
            end
        end

        // Read data stands in the cycle after the strobe
        if (bus.rd) begin
            if (bus.addr == `MTD_A_CTRL) begin
                d.rdata = {27'h0, q.ctrl};
            end else if (bus.addr == `MTD_A_STATUS) begin
                d.rdata = {24'h0, q.kst.got, 1'b0, q.busy,
                           q.vd.rejected, q.vd.accepted};
            end else if (bus.addr == `MTD_A_POWER) begin
                d.rdata = {16'h0, q.power};
            end else if (bus.addr == `MTD_A_UNBAL) begin
                d.rdata = {16'h0, q.unbal};
            end else if (bus.addr == `MTD_A_WATER) begin
                d.rdata = {16'h0, q.water};
            end else if (bus.addr == `MTD_A_CLRSEL) begin
                d.rdata = {16'h0, q.clrsel};
            end else if (bus.addr == `MTD_A_KEY0) begin
                d.rdata = q.key_live[31:0];
            end else if (bus.addr == `MTD_A_KEY1) begin
                d.rdata = q.key_live[63:32];
            end else if (bus.addr == `MTD_A_KEY2) begin
                d.rdata = q.key_live[95:64];
            end else if (bus.addr == `MTD_A_KEY3) begin
                d.rdata = q.key_live[127:96];
            end else if (bus.addr == `MTD_A_KEYINFO) begin
                d.rdata = {9'h0, q.kst.tariff, q.kst.kind, q.kst.rollover,
                           q.kst.revision, q.kst.expiry};
            end else if (bus.addr == `MTD_A_SUPPLY) begin
                d.rdata = {8'h0, q.sg_live};
            end else if (bus.addr == `MTD_A_TESTCTL) begin
                d.rdata = q.testctl[31:0];
            end else if (bus.addr == `MTD_A_MAKER) begin
                d.rdata = {16'h0, q.maker};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q    <= '0;
            q.st <= MTD_IDLE;
        end else begin
            q <= d;
        end
    end

    assign tok_busy         = q.busy;
    assign rdata            = q.rdata;
    assign credit_clear_sel = q.clrsel;
    assign credit_clear     = q.clr_pulse;
    assign tamper_clear     = q.tamper_clr;
    assign test_control     = q.testctl;
    assign test_start       = q.test_go;
    assign maker_payload    = q.maker;
    assign maker_start      = q.maker_go;
    assign verdict          = q.vd;

    // Bad checksum leads to rejection one cycle after capture
    property p_reject_bad;
        @(posedge clk) disable iff (!rstn)
        (q.st == MTD_CHECK && !crc_ok) |=> q.vd.rejected && !q.vd.accepted;
    endproperty
    a_bad_crc_reject: assert property (p_reject_bad)
        else $error("bad checksum not rejected");

    a_power_load: assert property (
        @(posedge clk) disable iff (!rstn)
        (q.st == MTD_APPLY && cls == `MTD_CLS_MGMT && sub == `MTD_S_POWER)
        |=> q.power == $past(q.tok[`MTD_VAL16_HI:`MTD_VAL16_LO]))
        else $error("power limit not loaded");

    a_clear_pulse: assert property (
        @(posedge clk) disable iff (!rstn)
        credit_clear |-> credit_clear_sel == $past(val16(q.tok)))
        else $error("clear select mismatch");

    a_tamper_clear: assert property (
        @(posedge clk) disable iff (!rstn)
        tamper_clear |-> $past(q.st) == MTD_APPLY && $past(sub) == `MTD_S_TAMPER)
        else $error("tamper clear without token");

    a_unbal_load: assert property (
        @(posedge clk) disable iff (!rstn)
        $changed(q.unbal) |-> $past(q.st) == MTD_APPLY
                            && $past(sub) == `MTD_S_UNBAL)
        else $error("unbalance limit changed wrongly");

    a_water_load: assert property (
        @(posedge clk) disable iff (!rstn)
        $changed(q.water) |-> $past(sub) == `MTD_S_WATER)
        else $error("water factor changed wrongly");

    a_class3_none: assert property (
        @(posedge clk) disable iff (!rstn)
        (q.st == MTD_CHECK && cls == `MTD_CLS_RSVD) |=> q.vd.rejected)
        else $error("class 3 token acted on");

    a_maker_start: assert property (
        @(posedge clk) disable iff (!rstn)
        maker_start |-> $past(q.st) == MTD_APPLY
            && $past(cls) == `MTD_CLS_MGMT
            && $past(sub) >= `MTD_S_MAKER_LO)
        else $error("maker action without token");

    sequence s_take;
        q.st == MTD_IDLE && tok_valid;
    endsequence
    a_token_flow: assert property (
        @(posedge clk) disable iff (!rstn)
        s_take |=> q.st == MTD_CHECK ##[1:2] (q.vd.accepted || q.vd.rejected)
                   ##1 !tok_busy)
        else $error("token did not complete");

    a_key_commit: assert property (
        @(posedge clk) disable iff (!rstn)
        (q.key_done && q.ctrl[`MTD_C_WIDE_KEY]) |-> q.kst.got == 4'h0
            && q.key_live == $past(q.kst.key))
        else $error("wide key not committed");
endmodule // mtd_token_decoder
`default_nettype wire

// ===== tb/mtd_carrier_model.sv
/*
 * Token carrier model: frames a 50-bit body with its check word and
 * strobes it into the decoder once the decoder is idle.
 * Assumes the bench raises send until sent answers.
 */
`timescale 1ns/1ps
`default_nettype none
module mtd_carrier_model
    import mtd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // From bench
    input  wire logic        send,
    input  wire logic [49:0] body,
    input  wire logic        corrupt,
    output var  logic        sent,
    // To decoder
    input  wire logic        tok_busy,
    output var  mtd_tok_t    tok_in,
    output var  logic        tok_valid
);
    int gap;

    function automatic logic [15:0] crc(input logic [49:0] b);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 49; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction

    always @(posedge clk) begin
        sent <= 1'b0;
        tok_valid <= 1'b0;
        if (gap > 0) gap <= gap - 1;
        // Released lines do not keep the last token
        if (tok_valid) tok_in <= ~tok_in;
        if (!rstn) begin
            gap <= 1;
            tok_in <= '0;
        end else if (send && !sent && gap == 0 && !tok_busy && !tok_valid) begin
            tok_in <= {body, crc(body) ^ {15'h0, corrupt}};
            tok_valid <= 1'b1;
            sent <= 1'b1;
            gap <= 4;
        end
    end
endmodule // mtd_carrier_model
`default_nettype wire

// ===== tb/meter_mgmt_token_decoder_tb_top.sv
/*
 * Self-checking bench of the token decoder with a carrier model.
 * Assumes register indices and control bits as the decoder defines.
 */
`timescale 1ns/1ps
`default_nettype none
module meter_mgmt_token_decoder_tb_top;
    import mtd_pkg::*;
    logic clk, rstn, tok_valid, tok_busy, tamper_in, send, corrupt, sent;
    logic credit_clear, tamper_clear, test_start, maker_start;
    logic [49:0] body;
    mtd_tok_t tok_in;
    mtd_bus_s bus;
    logic [31:0] rdata;
    logic [15:0] credit_clear_sel, maker_payload;
    logic [35:0] test_control;
    mtd_verdict_s verdict;
    logic [3:0] pl;
    int errors, comparisons, cycles;

    mtd_token_decoder i_dut (.clk(clk), .rstn(rstn), .tok_in(tok_in),
        .tok_valid(tok_valid), .tok_busy(tok_busy), .bus(bus), .rdata(rdata),
        .tamper_in(tamper_in), .credit_clear_sel(credit_clear_sel),
        .credit_clear(credit_clear), .tamper_clear(tamper_clear),
        .test_control(test_control), .test_start(test_start),
        .maker_payload(maker_payload), .maker_start(maker_start),
        .verdict(verdict));
    mtd_carrier_model i_car (.clk(clk), .rstn(rstn), .send(send), .body(body),
        .corrupt(corrupt), .sent(sent), .tok_busy(tok_busy), .tok_in(tok_in),
        .tok_valid(tok_valid));

    task automatic summarize();
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [127:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [43:0] rnd44();
        return {12'($urandom), $urandom};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask

    // Send one token, wait for its verdict and catch the action pulses
    task automatic tok(input logic [1:0] cls, input logic [3:0] sub,
                       input logic [43:0] rest, input logic bad, acc);
        int n;
        @(posedge clk);
        body <= {cls, sub, rest};
        corrupt <= bad;
        send <= 1'b1;
        #1;
        n = 0;
        while (verdict.accepted !== 1'b1 && verdict.rejected !== 1'b1
               && n < 40) begin
            @(posedge clk);
            #1;
            n++;
            if (sent) send <= 1'b0;
        end
        pl = {credit_clear, tamper_clear, test_start, maker_start};
        chk("verdict", {verdict.accepted, verdict.rejected}, {acc, !acc});
        if (!acc) chk("actions", pl, 4'h0);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        logic [15:0] v;
        logic [31:0] kh, kl, m1, m2;
        logic [43:0] r;
        rstn = 1'b0; tamper_in = 1'b0; send = 1'b0; corrupt = 1'b0;
        body = '0; bus = '0; errors = 0; comparisons = 0; cycles = 0;
        void'($urandom(94250));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 16; a++) rd(4'(a), 32'h0);
        for (int i = 0; i < 3; i++) begin
            v = 16'($urandom);
            tok(2'h2, (i == 0) ? 4'h0 : 4'(i + 5), {28'($urandom), v}, 0, 1);
            rd(4'(i + 2), {16'h0, v});
            tok(2'h2, (i == 0) ? 4'h0 : 4'(i + 5), {28'($urandom), ~v}, 1, 0);
            rd(4'(i + 2), {16'h0, v});
        end
        v = 16'($urandom);
        tok(2'h2, 4'h1, {28'($urandom), v}, 1'b0, 1'b1);
        chk("clear", {pl[3], credit_clear_sel}, {1'b1, v});
        tok(2'h2, 4'h2, rnd44(), 1'b0, 1'b0);
        tok(2'h2, 4'ha, rnd44(), 1'b0, 1'b0);
        tok(2'h3, 4'($urandom), rnd44(), 1'b0, 1'b0);
        for (int s = 11; s < 16; s++) begin
            v = 16'($urandom);
            tok(2'h2, 4'(s), {28'($urandom), v}, 1'b0, 1'b1);
            chk("maker", {pl[0], maker_payload}, {1'b1, v});
        end
        @(posedge clk);
        tamper_in <= 1'b1;
        @(posedge clk);
        tamper_in <= 1'b0;
        rd(4'h0, 32'h10);
        tok(2'h2, 4'h5, {28'($urandom), 16'h0}, 1'b0, 1'b1);
        chk("tamper_clear", pl[2], 1'b1);
        rd(4'h0, 32'h0);
        for (int c = 0; c < 4; c++) for (int s = 0; s < 2; s++) begin
            r = {28'($urandom), 16'h0};
            wr(4'h0, 32'(c));
            tok(2'h1, 4'(s), r, 1'b0, (s == c % 2) || c > 1);
            if (s == c % 2 || c > 1)
                chk("test", {pl[1], test_control},
                    {1'b1, (s == 1) ? {8'h0, r[43:16]} : r[43:8]});
        end
        kh = $urandom; kl = $urandom; m1 = $urandom; m2 = $urandom;
        wr(4'h0, 32'h0);
        tok(2'h2, 4'h3, {4'h1, 4'h9, 1'b1, 1'b0, 2'h3, kh}, 0, 1);
        tok(2'h2, 4'h4, {4'h2, 8'd99, kl}, 1'b0, 1'b1);
        rd(4'h6, kl);
        rd(4'h7, kh);
        rd(4'ha, {9'h0, 8'd99, 2'h3, 1'b1, 4'h9, 4'h1, 4'h2});
        wr(4'h0, 32'h4);
        tok(2'h2, 4'h3, {4'h1, 4'h1, 1'b0, 1'b1, 2'h0, kl}, 0, 1);
        tok(2'h2, 4'h4, {4'h2, 8'd0, kh}, 1'b0, 1'b1);
        tok(2'h2, 4'h8, {24'hf4240, 20'h0}, 1'b0, 1'b0);
        tok(2'h2, 4'h8, {24'hf423f, 20'h1}, 1'b0, 1'b0);
        tok(2'h2, 4'h8, {24'hf423f, 20'h0}, 1'b0, 1'b1);
        rd(4'hb, 32'hf423f);
        rd(4'h6, kh);
        wr(4'h0, 32'h8);
        tok(2'h2, 4'h3, {4'h1, 4'h5, 1'b0, 1'b0, 2'h1, kh}, 0, 1);
        tok(2'h2, 4'h4, {4'h3, 8'd7, kl}, 1'b0, 1'b1);
        tok(2'h2, 4'h9, {12'habc, m1}, 1'b0, 1'b1);
        tok(2'h2, 4'h8, {12'h123, m2}, 1'b0, 1'b1);
        rd(4'h6, kl);
        rd(4'h7, m1);
        rd(4'h8, m2);
        rd(4'h9, kh);
        rd(4'hb, 32'habc123);
        summarize();
    end
endmodule // meter_mgmt_token_decoder_tb_top
`default_nettype wire
